// ==== logic/ieb_defines.svh ====
// Offsets, field masks and reset values of the interrupt enable bank
`ifndef IEB_DEFINES_SVH
`define IEB_DEFINES_SVH
`define IEB_OFF_GROUP1 12'h000
`define IEB_OFF_GROUP4 12'h004
`define IEB_OFF_STATUS 12'h008
`define IEB_OFF_CLEAR 12'h00c
`define IEB_OFF_EVTEN 12'h010
`define IEB_OFF_PENDING 12'h014
`define IEB_MASK_GROUP1 16'hfedf
`define IEB_MASK_GROUP4 16'h3ffe
`define IEB_RST_ENABLE 16'h0000
`define IEB_RST_EVT 2'h0
`define IEB_RESP_OKAY 2'h0
`define IEB_RESP_SLVERR 2'h2
`define IEB_WORD_LSB 2
`endif

// ==== logic/ieb_pkg.sv ====
// Types shared by the interrupt enable bank
package ieb_pkg;
    typedef struct packed {
        logic [15:0] group1;
        logic [15:0] group4;
    } ieb_enables_t;

    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } ieb_wreq_t;

    typedef enum logic [1:0] {
        IEB_W_IDLE,
        IEB_W_RESP
    } ieb_wstate_t;
endpackage : ieb_pkg

// ==== logic/ieb_gate.sv ====
// Pending and enable gating for one group of sources
module ieb_gate #(
    parameter int WIDTH = 16
) (
    // Inputs
    input wire logic [WIDTH-1:0] pending,
    input wire logic [WIDTH-1:0] enable,
    input wire logic [WIDTH-1:0] implMask,
    // Output
    output logic [WIDTH-1:0] request,
    output logic anyRequest
);
    always_comb begin
        request = pending & enable & implMask;
        anyRequest = |request;
    end
endmodule : ieb_gate

// ==== logic/ieb_bank.sv ====
// Interrupt enable bank with AXI4-Lite register access
// Summary of operation
// - Implemented bits read/write, clear at reset; unimplemented read zero.
// - Group1 bits 15..9: uart2 tx/rx, ext2, timer5, timer4, oc4, oc3; bit8 none.
// - Group1 bits 7..0: ic8, ic7, none, ext1, change, comparator, i2c1 master/slave.
// - Group4 bits 15..14 none; 13..8: ic9, oc9, spi3 event/fault, uart4 tx/rx.
// - Group4 bits 7..1: uart4 err, usb, i2c3 master/slave, uart3 tx/rx/err; bit0 none.
`include "ieb_defines.svh"
module ieb_bank (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // AXI4-Lite write
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Peripheral pending flags
    input wire logic [15:0] pendGroup1,
    input wire logic [15:0] pendGroup4,
    // Gated requests to priority logic, and the event interrupt level
    output logic [15:0] reqGroup1,
    output logic [15:0] reqGroup4,
    output logic irqOut
);
    typedef struct packed {
        ieb_pkg::ieb_enables_t en;
        logic [1:0] evtStatus;
        logic [1:0] evtEnable;
        logic [1:0] prevAny;
        logic awHeld;
        logic wHeld;
        logic [11:0] awAddr;
        logic [31:0] wData;
        logic [3:0] wStrb;
        ieb_pkg::ieb_wstate_t wState;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } ieb_state_t;

    ieb_state_t st;
    ieb_state_t next_st;
    logic any1;
    logic any4;
    logic [1:0] rise;
    logic doWrite;
    logic [11:0] wAddr;

    ieb_gate #(.WIDTH(16)) gate1 (
        .pending(pendGroup1),
        .enable(st.en.group1),
        .implMask(`IEB_MASK_GROUP1),
        .request(reqGroup1),
        .anyRequest(any1)
    );
    ieb_gate #(.WIDTH(16)) gate4 (
        .pending(pendGroup4),
        .enable(st.en.group4),
        .implMask(`IEB_MASK_GROUP4),
        .request(reqGroup4),
        .anyRequest(any4)
    );

    // Merge byte lanes of a write into a 16-bit register under its mask
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] s, input logic [15:0] m);
        logic [15:0] v;
        v = old;
        if (s[0]) begin
            v[7:0] = d[7:0];
        end
        if (s[1]) begin
            v[15:8] = d[15:8];
        end
        merge16 = v & m;
    endfunction : merge16

    function automatic logic [11:0] wordOf(input logic [11:0] a);
        wordOf = {a[11:`IEB_WORD_LSB], 2'h0};
    endfunction : wordOf

    assign s_axi_awready = !st.awHeld && st.wState == ieb_pkg::IEB_W_IDLE;
    assign s_axi_wready = !st.wHeld && st.wState == ieb_pkg::IEB_W_IDLE;
    assign s_axi_bvalid = st.wState == ieb_pkg::IEB_W_RESP;
    assign s_axi_bresp = st.bresp;
    assign s_axi_arready = !st.rvalid;
    assign s_axi_rvalid = st.rvalid;
    assign s_axi_rdata = st.rdata;
    assign s_axi_rresp = st.rresp;
    // Level output: high while an enabled sticky event is set
    assign irqOut = |(st.evtStatus & st.evtEnable);

    always_comb begin
        next_st = st;
        rise = {any4, any1} & ~st.prevAny;
        next_st.prevAny = {any4, any1};
        if (s_axi_awvalid && s_axi_awready) begin
            next_st.awHeld = 1'b1;
            next_st.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_st.wHeld = 1'b1;
            next_st.wData = s_axi_wdata;
            next_st.wStrb = s_axi_wstrb;
        end
        doWrite = st.awHeld && st.wHeld && st.wState == ieb_pkg::IEB_W_IDLE;
        wAddr = wordOf(st.awAddr);
        if (doWrite) begin
            next_st.awHeld = 1'b0;
            next_st.wHeld = 1'b0;
            next_st.wState = ieb_pkg::IEB_W_RESP;
            next_st.bresp = `IEB_RESP_OKAY;
            case (wAddr)
                `IEB_OFF_GROUP1: begin
                    next_st.en.group1 = merge16(st.en.group1, st.wData, st.wStrb,
                                                `IEB_MASK_GROUP1);
                end
                `IEB_OFF_GROUP4: begin
                    next_st.en.group4 = merge16(st.en.group4, st.wData, st.wStrb,
                                                `IEB_MASK_GROUP4);
                end
                `IEB_OFF_CLEAR: begin
                    if (st.wStrb[0]) begin
                        next_st.evtStatus = st.evtStatus & ~st.wData[1:0];
                    end
                end
                `IEB_OFF_EVTEN: begin
                    if (st.wStrb[0]) begin
                        next_st.evtEnable = st.wData[1:0];
                    end
                end
                `IEB_OFF_STATUS, `IEB_OFF_PENDING: begin
                end
                default: begin
                    next_st.bresp = `IEB_RESP_SLVERR;
                end
            endcase
        end
        // Set wins over a clear in the same cycle
        next_st.evtStatus = next_st.evtStatus | rise;
        case (st.wState)
            ieb_pkg::IEB_W_RESP: begin
                if (s_axi_bready) begin
                    next_st.wState = ieb_pkg::IEB_W_IDLE;
                end
            end
            default: begin
            end
        endcase
        if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end
        if (s_axi_arvalid && !st.rvalid) begin
            next_st.rvalid = 1'b1;
            next_st.rresp = `IEB_RESP_OKAY;
            next_st.rdata = 32'h0;
            case (wordOf(s_axi_araddr))
                `IEB_OFF_GROUP1: next_st.rdata = {16'h0, st.en.group1};
                `IEB_OFF_GROUP4: next_st.rdata = {16'h0, st.en.group4};
                `IEB_OFF_STATUS: next_st.rdata = {30'h0, st.evtStatus};
                `IEB_OFF_EVTEN: next_st.rdata = {30'h0, st.evtEnable};
                `IEB_OFF_PENDING: next_st.rdata = {reqGroup4, reqGroup1};
                `IEB_OFF_CLEAR: next_st.rdata = 32'h0;
                default: next_st.rresp = `IEB_RESP_SLVERR;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st <= '0;
            st.en.group1 <= `IEB_RST_ENABLE;
            st.en.group4 <= `IEB_RST_ENABLE;
            st.evtStatus <= `IEB_RST_EVT;
            st.wState <= ieb_pkg::IEB_W_IDLE;
        end else begin
            st <= next_st;
        end
    end

    // External interrupt enables are plain bits; pin routing is software's job

    gate_blocks_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (reqGroup1 & ~st.en.group1) == 16'h0 && (reqGroup4 & ~st.en.group4) == 16'h0)
        else $error("request passed a cleared enable");
    gate_passes_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        reqGroup1 == (pendGroup1 & st.en.group1) && reqGroup4 == (pendGroup4 & st.en.group4))
        else $error("request not pending and enable");
    unimpl_zero_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (st.en.group1 & ~`IEB_MASK_GROUP1) == 16'h0
        && (st.en.group4 & ~`IEB_MASK_GROUP4) == 16'h0)
        else $error("unimplemented enable bit set");
    reset_clear_a: assert property (@(posedge core_clk)
        !rst_n |=> st.en == '0 && !s_axi_bvalid && !s_axi_rvalid)
        else $error("enables not cleared by reset");
    group1_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        doWrite && wAddr == `IEB_OFF_GROUP1 && st.wStrb == 4'hf
        |=> st.en.group1 == ($past(st.wData[15:0]) & `IEB_MASK_GROUP1))
        else $error("group1 write not stored");
    group4_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        doWrite && wAddr == `IEB_OFF_GROUP4 && st.wStrb == 4'hf
        |=> st.en.group4 == ($past(st.wData[15:0]) & `IEB_MASK_GROUP4))
        else $error("group4 write not stored");
    read_back_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_axi_arvalid && s_axi_arready && wordOf(s_axi_araddr) == `IEB_OFF_GROUP1
        |=> s_axi_rvalid && s_axi_rdata == {16'h0, $past(st.en.group1)})
        else $error("group1 read wrong");
    // Sticky bit falls only through a clear write or reset, never by disabling a source
    flag_kept_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        st.evtStatus[0]
        && !(doWrite && wAddr == `IEB_OFF_CLEAR && st.wStrb[0] && st.wData[0])
        |=> st.evtStatus[0])
        else $error("event flag lost without a clear");
    write_cov: cover property (@(posedge core_clk) s_axi_bvalid && s_axi_bready);
    read_cov: cover property (@(posedge core_clk) s_axi_rvalid && s_axi_rready);
    irq_cov: cover property (@(posedge core_clk) irqOut);
endmodule : ieb_bank

// ==== sim/ieb_prio_model.sv ====
// Priority logic stand-in that captures the gated requests each cycle
module ieb_prio_model (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Gated requests
    input wire logic [15:0] reqGroup1,
    input wire logic [15:0] reqGroup4,
    // Captured request vector
    output logic [31:0] seenReq
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            seenReq <= 32'h0;
        end else begin
            seenReq <= {reqGroup4, reqGroup1};
        end
    end
endmodule : ieb_prio_model

// ==== sim/tb.sv ====
// Self-checking bench for the interrupt enable bank
`include "ieb_defines.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, rst_n, irqOut;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, seenReq, seed, rd, d;
    logic [3:0] s_axi_wstrb, s;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [15:0] pendGroup1, pendGroup4, reqGroup1, reqGroup4, en1, en4;
    int miscompares, samplesChecked;
    ieb_bank dut (.core_clk(core_clk), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .pendGroup1(pendGroup1),
        .pendGroup4(pendGroup4), .reqGroup1(reqGroup1), .reqGroup4(reqGroup4), .irqOut(irqOut));
    ieb_prio_model partner (.core_clk(core_clk), .rst_n(rst_n), .reqGroup1(reqGroup1),
        .reqGroup4(reqGroup4), .seenReq(seenReq));
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], 1'b0} ^ (v[31] ? 32'h04c11db7 : 32'h0);
    endfunction : lfsr
    // Byte lanes 2 and 3 never reach the 16-bit enables
    function automatic logic [15:0] merge(input logic [15:0] o, input logic [15:0] n,
                                          input logic [3:0] st, input logic [15:0] m);
        return ((o & ~{{8{st[1]}}, {8{st[0]}}}) | (n & {{8{st[1]}}, {8{st[0]}}})) & m;
    endfunction : merge
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic chkResp(input logic [1:0] got, input logic [1:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t resp got=%h exp=%h", $time, got, exp);
        end
    endtask : chkResp
    task automatic chkIrq(input logic got, input logic exp);
        samplesChecked++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t irq got=%h exp=%h", $time, got, exp);
        end
    endtask : chkIrq
    task automatic closeOut();
        if (miscompares == 0 && samplesChecked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : closeOut
    task automatic wr(input logic [11:0] a, input logic [31:0] wd, input logic [3:0] st);
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= wd;
        s_axi_wstrb <= st;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!(s_axi_bvalid && s_axi_bready));
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rdr(input logic [11:0] a);
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!(s_axi_rvalid && s_axi_rready));
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rdr
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    initial begin
        repeat (6000) @(posedge core_clk);
        miscompares++;
        closeOut();
    end
    initial begin
        {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        {pendGroup1, pendGroup4, en1, en4} = '0;
        seed = 32'h538caaa6;
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        rdr(`IEB_OFF_GROUP1);
        chk(rd, 32'h0);
        rdr(`IEB_OFF_GROUP4);
        chk(rd, 32'h0);
        // Walking one over every position, then random data and lanes
        // Ext irq enables presume software has routed their input pins
        for (int i = 0; i < 28; i++) begin
            seed = lfsr(seed);
            d = (i < 16) ? {2{16'h1 << i}} : seed;
            s = (i < 16) ? 4'hf : seed[7:4];
            wr(`IEB_OFF_GROUP1, d, s);
            chkResp(resp, `IEB_RESP_OKAY);
            en1 = merge(en1, d[15:0], s, `IEB_MASK_GROUP1);
            wr(`IEB_OFF_GROUP4, d, s);
            chkResp(resp, `IEB_RESP_OKAY);
            en4 = merge(en4, d[15:0], s, `IEB_MASK_GROUP4);
            rdr(`IEB_OFF_GROUP1);
            chk(rd, {16'h0, en1});
            rdr(`IEB_OFF_GROUP4);
            chk(rd, {16'h0, en4});
            pendGroup1 <= (i < 16) ? 16'hffff : seed[31:16];
            pendGroup4 <= (i < 16) ? 16'hffff : ~seed[15:0];
            @(posedge core_clk);
            @(posedge core_clk);
            chk({reqGroup4, reqGroup1}, {en4 & pendGroup4, en1 & pendGroup1});
            @(posedge core_clk);
            chk(seenReq, {en4 & pendGroup4, en1 & pendGroup1});
            rdr(`IEB_OFF_PENDING);
            chk(rd, {en4 & pendGroup4, en1 & pendGroup1});
        end
        pendGroup1 <= 16'h0;
        pendGroup4 <= 16'h0;
        wr(`IEB_OFF_GROUP1, 32'hffff, 4'h3);
        wr(`IEB_OFF_GROUP4, 32'hffff, 4'h3);
        wr(`IEB_OFF_EVTEN, 32'h3, 4'hf);
        wr(`IEB_OFF_CLEAR, 32'h3, 4'hf);
        pendGroup1 <= 16'h0001;
        repeat (3) @(posedge core_clk);
        chkIrq(irqOut, 1'b1);
        rdr(`IEB_OFF_STATUS);
        chk(rd, 32'h1);
        wr(`IEB_OFF_CLEAR, 32'h1, 4'hf);
        repeat (2) @(posedge core_clk);
        chkIrq(irqOut, 1'b0);
        rdr(`IEB_OFF_CLEAR);
        chk(rd, 32'h0);
        wr(`IEB_OFF_EVTEN, 32'h0, 4'hf);
        pendGroup4 <= 16'h0002;
        repeat (3) @(posedge core_clk);
        chkIrq(irqOut, 1'b0);
        rdr(`IEB_OFF_STATUS);
        chk(rd, 32'h2);
        wr(`IEB_OFF_EVTEN, 32'h2, 4'hf);
        repeat (2) @(posedge core_clk);
        chkIrq(irqOut, 1'b1);
        // Disabling blocks the request though the flag stays up
        wr(`IEB_OFF_GROUP4, 32'h0, 4'h3);
        chk({reqGroup4, reqGroup1}, 32'h0001);
        rdr(`IEB_OFF_STATUS);
        chk(rd, 32'h2);
        wr(12'h020, 32'hffff, 4'hf);
        chkResp(resp, `IEB_RESP_SLVERR);
        rdr(12'h020);
        chkResp(resp, `IEB_RESP_SLVERR);
        closeOut();
    end
endmodule : tb
